// ==== adcsc_pkg.sv ====
// package for the converter scan, compare-hit and reference control block
// assumes a 32-bit ahb-lite register bus, one word per register
package adcsc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_BAND_GAP_ENABLES = 8'h00;
  localparam logic [7:0] ADDR_COMPARE_HIT_LOW = 8'h04;
  localparam logic [7:0] ADDR_COMPARE_HIT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_SCAN_SELECT_LOW = 8'h0c;
  localparam logic [7:0] ADDR_SCAN_SELECT_HIGH = 8'h10;
  localparam logic [7:0] ADDR_MEASURE_CONNECT_LOW = 8'h14;
  localparam logic [7:0] ADDR_MEASURE_CONNECT_HIGH = 8'h18;
  localparam logic [7:0] ADDR_CONTROL = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h28;
  // implemented bit masks
  localparam logic [15:0] BAND_GAP_MASK = 16'h003f;
  localparam logic [15:0] HIT_HIGH_MASK = 16'h03ff;
  localparam logic [15:0] SEL_HIGH_MASK = 16'h73ff;
  localparam logic [15:0] SMALL_HIGH_MASK = 16'h7300;
  // band gap bit positions
  localparam int BG_SIXTH_XCVR = 5;
  localparam int BG_HALF_CMP = 4;
  localparam int BG_DAC = 3;
  localparam int BG_ANALOG = 2;
  localparam int BG_CONVERTER = 1;
  localparam int BG_GENERAL = 0;
  // control register: divisor in 7:0, compare mode in 9:8
  localparam int CTRL_DIV_LSB = 0;
  localparam int CTRL_MODE_LSB = 8;
  localparam logic [15:0] CTRL_MASK = 16'h03ff;
  // instruction cycle is this many oscillator periods
  localparam int OSC_PER_INSTR = 2;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  typedef enum logic [1:0] {
    ADCSC_LESS = 2'b00,
    ADCSC_GREATER = 2'b01,
    ADCSC_INSIDE = 2'b10,
    ADCSC_OUTSIDE = 2'b11
  } adcsc_mode_t;
  // conversion event reported by the scan sequencer
  typedef struct packed {
    logic valid;
    logic [4:0] channel;
    logic buf_written;
    logic match;
  } adcsc_conv_t;
endpackage

// ==== adcsc_top.sv ====
// converter scan select, compare-hit flags, reference enables, ahb slave
// assumes sequencer, compare hardware and analog core on hclk
`timescale 1ns/1ns
module adcsc_top
  import adcsc_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire adcsc_conv_t conv_evt,
  input wire logic [4:0] conv_active_ch,
  input wire logic conv_active,
  input wire logic [5:0] consumer_req,
  output logic [5:0] ref_on,
  output logic [31:0] scan_include_bits,
  output logic measure_unit_connect,
  output logic [7:0] conv_clock_divisor,
  output logic [15:0] conv_clock_period_osc,
  output adcsc_mode_t compare_mode_field,
  output logic irq
);
  // ==========================================================
  // bus slave
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic rd_go;
  logic [15:0] band_gap_ff;
  logic [25:0] hit_ff;
  logic [31:0] scan_ff;
  logic [31:0] meas_ff;
  logic [15:0] ctrl_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_en_ff;
  logic [15:0] wd;
  logic [31:0] impl_mask;
  logic [31:0] nxt_hrdata;
  logic [25:0] hit_set;
  logic [25:0] hit_mask;

  // channels 16..23 missing on the small package
  assign impl_mask = SMALL_PACKAGE ? {1'b0, SMALL_HIGH_MASK[14:8], 8'h00,
    16'hffff} : {1'b0, SEL_HIGH_MASK[14:0], 16'hffff};
  // hit flags 16..25 are all missing on the small package
  assign hit_mask = SMALL_PACKAGE ? 26'h000ffff : 26'h3ffffff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wd = hwdata[15:0];
  assign rd_go = hsel && hready && htrans[1] && !hwrite;

  // capture address phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= hsel && htrans[1] && hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  function automatic logic wr_hit(input logic [7:0] a, input logic p,
                                  input logic [7:0] w);
    wr_hit = p && (a == w);
  endfunction

  // ==========================================================
  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      band_gap_ff <= RESET_VALUE;
      ctrl_ff <= RESET_VALUE;
    end else begin
      if (wr_hit(wr_addr_ff, wr_pend_ff, ADDR_BAND_GAP_ENABLES)) begin
        band_gap_ff <= wd & BAND_GAP_MASK;
      end
      if (wr_hit(wr_addr_ff, wr_pend_ff, ADDR_CONTROL)) begin
        ctrl_ff <= wd & CTRL_MASK;
      end
    end
  end

  // scan select and measure connect, two words each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_ff <= 32'h00000000;
      meas_ff <= 32'h00000000;
    end else begin
      if (wr_hit(wr_addr_ff, wr_pend_ff, ADDR_SCAN_SELECT_LOW)) begin
        scan_ff[15:0] <= wd & impl_mask[15:0];
      end
      if (wr_hit(wr_addr_ff, wr_pend_ff, ADDR_SCAN_SELECT_HIGH)) begin
        scan_ff[31:16] <= wd & impl_mask[31:16];
      end
      if (wr_hit(wr_addr_ff, wr_pend_ff, ADDR_MEASURE_CONNECT_LOW)) begin
        meas_ff[15:0] <= wd & impl_mask[15:0];
      end
      if (wr_hit(wr_addr_ff, wr_pend_ff, ADDR_MEASURE_CONNECT_HIGH)) begin
        meas_ff[31:16] <= wd & impl_mask[31:16];
      end
    end
  end

  // ==========================================================
  // compare-hit flags
  assign compare_mode_field = adcsc_mode_t'(ctrl_ff[CTRL_MODE_LSB +: 2]);

  // outside mode also flags plain buffer writes
  always_comb begin
    hit_set = '0;
    if (conv_evt.valid && conv_evt.channel < 5'd26) begin
      if (compare_mode_field == ADCSC_OUTSIDE) begin
        hit_set[conv_evt.channel] = conv_evt.buf_written ||
          conv_evt.match;
      end else begin
        hit_set[conv_evt.channel] = conv_evt.match;
      end
    end
    hit_set = hit_set & hit_mask;
  end

  // software write applies now; a same-cycle hit still wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_ff <= '0;
    end else begin
      if (wr_hit(wr_addr_ff, wr_pend_ff, ADDR_COMPARE_HIT_LOW)) begin
        hit_ff[15:0] <= wd | hit_set[15:0];
      end else begin
        hit_ff[15:0] <= hit_ff[15:0] | hit_set[15:0];
      end
      if (wr_hit(wr_addr_ff, wr_pend_ff, ADDR_COMPARE_HIT_HIGH)) begin
        hit_ff[25:16] <= (wd[9:0] & hit_mask[25:16]) | hit_set[25:16];
      end else begin
        hit_ff[25:16] <= hit_ff[25:16] | hit_set[25:16];
      end
    end
  end

  // ==========================================================
  // interrupt: bit0 any hit event, bit1 any conversion event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_ff <= 2'b00;
      irq_en_ff <= 2'b00;
    end else begin
      if (wr_hit(wr_addr_ff, wr_pend_ff, ADDR_IRQ_ENABLE)) begin
        irq_en_ff <= wd[1:0];
      end
      // set wins over clear
      irq_stat_ff <= (irq_stat_ff &
        ~(wr_hit(wr_addr_ff, wr_pend_ff, ADDR_IRQ_CLEAR) ? wd[1:0] : 2'b00))
        | {conv_evt.valid, |hit_set};
    end
  end
  assign irq = |(irq_stat_ff & irq_en_ff);

  // ==========================================================
  // outputs to analog and sequencer
  assign ref_on = band_gap_ff[5:0] | consumer_req;
  assign scan_include_bits = scan_ff;
  // connect only while that channel converts
  assign measure_unit_connect = conv_active &&
    meas_ff[conv_active_ch];
  assign conv_clock_divisor = ctrl_ff[CTRL_DIV_LSB +: 8];
  // period in oscillator cycles: 2 * (div + 1)
  assign conv_clock_period_osc = 16'(OSC_PER_INSTR) *
    (16'(conv_clock_divisor) + 16'h0001);

  // ==========================================================
  // read mux; enables read stored bits, not actual state
  // limitation: a read right behind a write to the same word sees the
  // old value, since the write lands on the read's address edge
  always_comb begin
    nxt_hrdata = 32'h00000000;
    case (haddr[7:0])
      ADDR_BAND_GAP_ENABLES: nxt_hrdata[15:0] = band_gap_ff;
      ADDR_COMPARE_HIT_LOW: nxt_hrdata[15:0] = hit_ff[15:0];
      ADDR_COMPARE_HIT_HIGH: nxt_hrdata[9:0] = hit_ff[25:16];
      ADDR_SCAN_SELECT_LOW: nxt_hrdata[15:0] = scan_ff[15:0];
      ADDR_SCAN_SELECT_HIGH: nxt_hrdata[15:0] = scan_ff[31:16];
      ADDR_MEASURE_CONNECT_LOW: nxt_hrdata[15:0] = meas_ff[15:0];
      ADDR_MEASURE_CONNECT_HIGH: nxt_hrdata[15:0] = meas_ff[31:16];
      ADDR_CONTROL: nxt_hrdata[15:0] = ctrl_ff;
      ADDR_IRQ_STATUS: nxt_hrdata[1:0] = irq_stat_ff;
      ADDR_IRQ_ENABLE: nxt_hrdata[1:0] = irq_en_ff;
      default: nxt_hrdata = 32'h00000000; // unmapped reads zero
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_go) begin
      hrdata <= nxt_hrdata;
    end
  end

  // ==========================================================
  // checks
  property p_hit_sticky;
    @(posedge hclk) disable iff (!hresetn)
      (hit_ff[0] && !(wr_pend_ff && wr_addr_ff == ADDR_COMPARE_HIT_LOW))
      |=> hit_ff[0];
  endproperty
  a_hit_sticky: assert property (p_hit_sticky)
    else $error("hit flag lost without write");

  property p_match_sets;
    @(posedge hclk) disable iff (!hresetn)
      (conv_evt.valid && conv_evt.match && conv_evt.channel == 5'd3)
      |=> hit_ff[3];
  endproperty
  a_match_sets: assert property (p_match_sets)
    else $error("match did not set flag");

  property p_outside_write;
    @(posedge hclk) disable iff (!hresetn)
      (conv_evt.valid && conv_evt.buf_written && conv_evt.channel == 5'd2
       && compare_mode_field == ADCSC_OUTSIDE) |=> hit_ff[2];
  endproperty
  a_outside_write: assert property (p_outside_write)
    else $error("outside mode write missed flag");

  property p_no_spurious;
    @(posedge hclk) disable iff (!hresetn)
      (!hit_ff[1] && !(conv_evt.valid && conv_evt.channel == 5'd1) &&
       !(wr_pend_ff && wr_addr_ff == ADDR_COMPARE_HIT_LOW)) |=> !hit_ff[1];
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("flag set without event");

  property p_ref_req;
    @(posedge hclk) disable iff (!hresetn)
      consumer_req[BG_DAC] |-> ref_on[BG_DAC];
  endproperty
  a_ref_req: assert property (p_ref_req)
    else $error("reference off while requested");

  property p_unimpl;
    @(posedge hclk) disable iff (!hresetn)
      band_gap_ff[15:6] == 10'h000 && (hit_ff & ~hit_mask) == 26'h0 &&
      scan_ff[31] == 1'b0 && scan_ff[27:26] == 2'b00 &&
      meas_ff[31] == 1'b0 && meas_ff[27:26] == 2'b00 &&
      ctrl_ff[15:10] == 6'h00;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bit set");

  property p_period;
    @(posedge hclk) disable iff (!hresetn)
      conv_clock_period_osc == {7'h00, conv_clock_divisor, 1'b0} + 16'h0002;
  endproperty
  a_period: assert property (p_period)
    else $error("conversion period wrong");

  sequence s_bg_read;
    rd_go && haddr[7:0] == ADDR_BAND_GAP_ENABLES;
  endsequence
  property p_bg_store;
    @(posedge hclk) disable iff (!hresetn)
      s_bg_read |=> hrdata[5:0] == $past(band_gap_ff[5:0]) &&
      hrdata[31:6] == 26'h0;
  endproperty
  a_bg_store: assert property (p_bg_store)
    else $error("enable readback wrong");

  property p_connect;
    @(posedge hclk) disable iff (!hresetn)
      !conv_active |-> !measure_unit_connect;
  endproperty
  a_connect: assert property (p_connect)
    else $error("unit connected outside conversion");

  // a zero written with no new hit clears the flag that very cycle
  sequence s_hit_low_zero;
    wr_pend_ff && wr_addr_ff == ADDR_COMPARE_HIT_LOW && !wd[0] &&
    !hit_set[0];
  endsequence
  property p_hit_clear;
    @(posedge hclk) disable iff (!hresetn)
      s_hit_low_zero |=> !hit_ff[0];
  endproperty
  a_hit_clear: assert property (p_hit_clear)
    else $error("hit flag not cleared by write");

  // a plain buffer write in any mode but outside must not raise flag 25
  property p_write_no_flag;
    @(posedge hclk) disable iff (!hresetn)
      (conv_evt.valid && conv_evt.buf_written && !conv_evt.match &&
       conv_evt.channel == 5'd25 && compare_mode_field != ADCSC_OUTSIDE &&
       !hit_ff[25] &&
       !(wr_pend_ff && wr_addr_ff == ADDR_COMPARE_HIT_HIGH)) |=> !hit_ff[25];
  endproperty
  a_write_no_flag: assert property (p_write_no_flag)
    else $error("flag set by plain buffer write");

  // with neither manual bit nor request the reference stays off
  property p_ref_off;
    @(posedge hclk) disable iff (!hresetn)
      !band_gap_ff[BG_HALF_CMP] && !consumer_req[BG_HALF_CMP]
      |-> !ref_on[BG_HALF_CMP];
  endproperty
  a_ref_off: assert property (p_ref_off)
    else $error("reference on without request");

  // internal channel 28 links the unit while it converts
  property p_connect_int;
    @(posedge hclk) disable iff (!hresetn)
      conv_active && conv_active_ch == 5'd28 && meas_ff[28]
      |-> measure_unit_connect;
  endproperty
  a_connect_int: assert property (p_connect_int)
    else $error("unit not linked to converting channel");

  // unused control bits never reach the bus
  property p_ctrl_read;
    @(posedge hclk) disable iff (!hresetn)
      rd_go && haddr[7:0] == ADDR_CONTROL |=> hrdata[31:10] == 22'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("unused control bits read back");
endmodule

// ==== tb.sv ====
// testbench for the scan, compare-hit and reference control block
// assumes a zero-wait ahb-lite slave and a single 20 mhz clock
`timescale 1ns/1ns
`define CHK(a, b) begin \
  num_checks++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); \
  end \
end
module tb;
  import adcsc_pkg::*;
  // ==========================================================
  // signals
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, measure_unit_connect, irq;
  logic [31:0] hrdata, scan_include_bits, hrdata_s, scan_s;
  logic conn_s;
  adcsc_conv_t conv_evt = '0;
  logic [4:0] conv_active_ch = '0;
  logic conv_active = 0;
  logic [5:0] consumer_req = '0;
  logic [5:0] ref_on;
  logic [7:0] conv_clock_divisor;
  logic [15:0] conv_clock_period_osc;
  adcsc_mode_t compare_mode_field;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] d0, d1, d2;
  logic [25:0] eh;
  logic [4:0] c;
  logic b, m;
  // ==========================================================
  // design, single slave so hready is its own hreadyout
  adcsc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .conv_evt(conv_evt),
    .conv_active_ch(conv_active_ch), .conv_active(conv_active),
    .consumer_req(consumer_req), .ref_on(ref_on),
    .scan_include_bits(scan_include_bits),
    .measure_unit_connect(measure_unit_connect),
    .conv_clock_divisor(conv_clock_divisor),
    .conv_clock_period_osc(conv_clock_period_osc),
    .compare_mode_field(compare_mode_field), .irq(irq));
  // small package copy shares the bus and the converter inputs
  adcsc_top #(.SMALL_PACKAGE(1'b1)) dut_small (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(), .hresp(), .hrdata(hrdata_s), .conv_evt(conv_evt),
    .conv_active_ch(conv_active_ch), .conv_active(conv_active),
    .consumer_req(consumer_req), .ref_on(), .scan_include_bits(scan_s),
    .measure_unit_connect(conn_s), .conv_clock_divisor(),
    .conv_clock_period_osc(), .compare_mode_field(), .irq());
  always #25 hclk = ~hclk;
  // ==========================================================
  // bus tasks, the master never assumes a wait count
  task automatic ahb(input logic [7:0] a, input logic wr,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(a, 1'b1, d, q);
  endtask
  // read and compare, the caller carries the tag
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(a, 1'b0, 32'h0, q);
    `CHK(q, e)
    `CHK(hresp, 1'b0)
  endtask
  // one-cycle conversion result pulse
  task automatic evt(input logic [4:0] ch, input logic bw, input logic mt);
    @(posedge hclk);
    conv_evt <= '{valid: 1'b1, channel: ch, buf_written: bw, match: mt};
    @(posedge hclk);
    conv_evt <= '0;
  endtask
  function automatic logic exp_hit(input logic [1:0] md, input logic bw,
                                   input logic mt);
    return mt | ((md == 2'b11) & bw);
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // hang guard, generous against some 300 cycles of tests
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("mismatch at %0t: timeout", $time);
      wrap_up();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hab900a63));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and the unmapped word at 2c
    for (int a = 0; a <= 8'h2c; a += 4) chk_rd(a[7:0], 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      d0 = $urandom;
      consumer_req <= 6'($urandom);
      wr(ADDR_BAND_GAP_ENABLES, d0);
      chk_rd(ADDR_BAND_GAP_ENABLES, d0 & 32'h3f);
      @(negedge hclk);
      `CHK(ref_on, d0[5:0] | consumer_req)
    end
    $display("test band gap done");
    d0 = $urandom;
    d1 = $urandom;
    wr(ADDR_SCAN_SELECT_LOW, d0);
    wr(ADDR_SCAN_SELECT_HIGH, d1);
    chk_rd(ADDR_SCAN_SELECT_LOW, {16'h0, d0[15:0]});
    chk_rd(ADDR_SCAN_SELECT_HIGH, {16'h0, d1[15:0] & SEL_HIGH_MASK});
    `CHK(scan_include_bits, {d1[15:0] & SEL_HIGH_MASK, d0[15:0]})
    `CHK(scan_s, {d1[15:0] & SMALL_HIGH_MASK, d0[15:0]})
    wr(ADDR_MEASURE_CONNECT_LOW, d0);
    wr(ADDR_MEASURE_CONNECT_HIGH, 32'hffffffff);
    d1 = {SEL_HIGH_MASK, d0[15:0]};
    d2 = {SMALL_HIGH_MASK, d0[15:0]};
    // every channel, converting or not, including the holes
    for (int ch = 0; ch < 32; ch++) begin
      @(posedge hclk);
      conv_active_ch <= ch[4:0];
      conv_active <= 1'($urandom);
      @(negedge hclk);
      `CHK(measure_unit_connect, conv_active & d1[ch])
      `CHK(conn_s, conv_active & d2[ch])
    end
    $display("test scan and connect done");
    for (int md = 0; md < 4; md++) begin
      d0 = $urandom & 32'hff;
      wr(ADDR_CONTROL, {22'h0, md[1:0], d0[7:0]});
      @(negedge hclk);
      `CHK(compare_mode_field, md[1:0])
      `CHK(conv_clock_divisor, d0[7:0])
      `CHK(conv_clock_period_osc, {7'h0, d0[7:0], 1'b0} + 16'h2)
      wr(ADDR_COMPARE_HIT_LOW, 32'h0);
      wr(ADDR_COMPARE_HIT_HIGH, 32'h0);
      eh = '0;
      // first a written buffer without a match on the top flag
      evt(5'd25, 1'b1, 1'b0);
      eh[25] = exp_hit(md[1:0], 1'b1, 1'b0);
      for (int i = 0; i < 8; i++) begin
        c = 5'($urandom % 26);
        b = 1'($urandom);
        m = 1'($urandom);
        evt(c, b, m);
        eh[c] = eh[c] | exp_hit(md[1:0], b, m);
      end
      chk_rd(ADDR_COMPARE_HIT_LOW, {16'h0, eh[15:0]});
      chk_rd(ADDR_COMPARE_HIT_HIGH, {22'h0, eh[25:16]});
      `CHK(hrdata_s, 32'h0)
      wr(ADDR_COMPARE_HIT_LOW, 32'h0);
      chk_rd(ADDR_COMPARE_HIT_LOW, 32'h0);
    end
    wr(ADDR_COMPARE_HIT_HIGH, 32'hffffffff);
    chk_rd(ADDR_COMPARE_HIT_HIGH, 32'h3ff);
    $display("test compare hits done");
    // interrupt raised, masked and cleared
    wr(ADDR_IRQ_CLEAR, 32'h3);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    @(negedge hclk);
    `CHK(irq, 1'b0)
    evt(5'd3, 1'b0, 1'b1);
    @(negedge hclk);
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_ENABLE, 32'h0);
    @(negedge hclk);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_ENABLE, 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h3);
    @(negedge hclk);
    `CHK(irq, 1'b0)
    chk_rd(ADDR_IRQ_STATUS, 32'h0);
    $display("test interrupt done");
    wrap_up();
  end
endmodule
